/* File: common/timer_cfg.svh */
// Constants for the gated sixteen-bit counter timer.
// Notes on behaviour
// - Clock select picks osc, pin, system, instruction.
// - Prescale divides selected clock by 1/2/4/8.
// - Sync bypass one skips resynchronisation of the prescaled clock.
// - On bit off stops counter, clears toggle flop.
// - Gate enable ignored while off, else gates.
// - Polarity picks high or low gate level.
// - Toggle bit enables toggle, zero clears flop.
// - Toggle flop flips on each gate rise.
// - Single-pulse bit lets acquisition control gate.
// - Software arms, hardware clears arm status bit.
// - Gate level bit shows qualifying gate state.
// - Gate source: pin, timer overflow, comparator.
// - Writable bits reset to zero on reset.
// - Control bits three and one read zero.
// - External clock needs falling edge before counting.
// - Count wraps FFFF to zero, sets overflow.
// - Pulse window opens on edge, closes trailing.
// - Gate level falling edge sets gate event.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// Register addresses on the plain register port
`define ADDR_CONTROL 3'h0
`define ADDR_GATE 3'h1
`define ADDR_COUNT_LO 3'h2
`define ADDR_COUNT_HI 3'h3
`define ADDR_STATUS 3'h4

// Writable bit masks
`define CONTROL_WMASK 8'hF5
`define GATE_WMASK 8'hF3

// Field positions
`define GATE_ARM_BIT 3
`define GATE_LEVEL_BIT 2
`define STAT_OVF_BIT 0
`define STAT_GATE_BIT 1

// Reset values
`define CONTROL_RESET 8'h00
`define GATE_RESET 8'h00
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hFFFF
`define READ_ZERO 8'h00

// Instruction clock is the system clock divided by four
`define INSTR_DIV_LAST 2'h3
`define INSTR_DIV_RESET 2'h0

// Prescaler masks for 1:1, 1:2, 1:4, 1:8
`define PRESC_MASK_1 3'h0
`define PRESC_MASK_2 3'h1
`define PRESC_MASK_4 3'h3
`define PRESC_MASK_8 3'h7
`define PRESC_RESET 3'h0

`endif

/* File: common/timer_pkg.sv */
// Types for the gated sixteen-bit counter timer.
package timer_pkg;

  // Counter control register layout
  typedef struct packed {
    logic [1:0] clock_select;
    logic [1:0] prescale_select;
    logic unused_3;
    logic sync_bypass;
    logic unused_1;
    logic counter_on;
  } ctrl_t;

  // Gate control register layout
  typedef struct packed {
    logic gate_enable;
    logic gate_polarity;
    logic gate_toggle_mode;
    logic gate_single_pulse_mode;
    logic pulse_arm_status;
    logic gate_level;
    logic [1:0] gate_source_select;
  } gcfg_t;

  // Counter clock sources
  typedef enum logic [1:0] {
    CLK_INSTR = 2'b00,
    CLK_SYSTEM = 2'b01,
    CLK_EXT_PIN = 2'b10,
    CLK_LFOSC = 2'b11
  } clk_src_t;

  // Gate sources
  typedef enum logic [1:0] {
    GSRC_PIN = 2'b00,
    GSRC_TIMER0 = 2'b01,
    GSRC_COMP = 2'b10,
    GSRC_RSVD = 2'b11
  } gate_src_t;

  // Single-pulse acquisition states
  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_ARMED = 2'b01,
    PULSE_OPEN = 2'b10
  } pulse_state_t;

endpackage

/* File: rtl/gated_counter_timer.sv */
// Gated sixteen-bit counter timer with register port.
`include "timer_cfg.svh"
module gated_counter_timer
  import timer_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic EXT_CLOCK_PIN,
  input wire logic LOW_FREQ_OSC,
  input wire logic GATE_PIN,
  input wire logic TIMER0_OVERFLOW,
  input wire logic COMPARATOR_SYNC_OUTPUT,
  output logic OVERFLOW_FLAG,
  output logic GATE_EVENT_FLAG,
  output logic GATE_LEVEL
);

  // Register state
  ctrl_t ctrl_q, ctrl_d; // Counter control
  gcfg_t gcfg_q, gcfg_d; // Gate configuration, arm and level held zero
  logic [15:0] count_q, count_d; // The count itself
  logic ovf_q, ovf_d; // Overflow flag
  logic gev_q, gev_d; // Gate event flag
  logic [7:0] rdata_q, rdata_d; // Read data, one cycle after strobe

  // Clock path state
  logic [1:0] instr_q, instr_d; // Divide-by-four for instruction clock
  logic fall_seen_q, fall_seen_d; // External pin has been low
  logic ptog_q, ptog_d; // Toggle carrying prescaler output

  // Gate path state
  logic gpol_q, gpol_d; // Previous polarity-corrected gate
  logic toggle_q, toggle_d; // Gate toggle flip-flop
  logic gmid_q, gmid_d; // Previous gate after toggle stage
  pulse_state_t pst_q, pst_d; // Single-pulse acquisition state
  logic glevel_q, glevel_d; // Final qualifying gate level

  // Synchronised inputs
  logic ext_level, ext_rise; // External clock pin
  logic lfo_rise; // Low-frequency oscillator
  logic gpin_level; // Gate pin
  logic ps_rise, ps_fall; // Resynchronised prescaler toggle

  // Combinational helpers
  logic instr_tick; // Instruction clock enable
  logic src_tick; // Selected clock enable
  logic presc_pulse; // Prescaler output
  logic is_async; // Source comes from outside the clock domain
  logic final_tick; // Clock enable reaching the counter
  logic gsrc; // Selected gate source
  logic gpol; // Gate after polarity
  logic gpol_rise; // Rising edge of polarity-corrected gate
  logic gmid; // Gate after toggle stage
  logic gmid_rise, gmid_fall; // Edges after toggle stage
  logic cnt_en; // Increment this cycle
  logic wr_ctrl, wr_gate, wr_lo, wr_hi, wr_stat; // Write decodes

  // Pin synchronisers
  sync_edge u_ext (
    .clk(MCLK),
    .rst(RST),
    .din(EXT_CLOCK_PIN),
    .level(ext_level),
    .rise(ext_rise),
    .fall()
  );

  sync_edge u_lfo (
    .clk(MCLK),
    .rst(RST),
    .din(LOW_FREQ_OSC),
    .level(),
    .rise(lfo_rise),
    .fall()
  );

  sync_edge u_gpin (
    .clk(MCLK),
    .rst(RST),
    .din(GATE_PIN),
    .level(gpin_level),
    .rise(),
    .fall()
  );

  // Optional resynchronisation of the prescaled asynchronous clock
  sync_edge u_psync (
    .clk(MCLK),
    .rst(RST),
    .din(ptog_q),
    .level(),
    .rise(ps_rise),
    .fall(ps_fall)
  );

  // Prescaler, held clear while the counter is off
  tick_prescaler u_presc (
    .clk(MCLK),
    .rst(RST),
    .clear(~ctrl_q.counter_on),
    .tick(src_tick),
    .sel(ctrl_q.prescale_select),
    .pulse(presc_pulse)
  );

  // Write decodes
  assign wr_ctrl = REG_WR && (REG_ADDR == `ADDR_CONTROL);
  assign wr_gate = REG_WR && (REG_ADDR == `ADDR_GATE);
  assign wr_lo = REG_WR && (REG_ADDR == `ADDR_COUNT_LO);
  assign wr_hi = REG_WR && (REG_ADDR == `ADDR_COUNT_HI);
  assign wr_stat = REG_WR && (REG_ADDR == `ADDR_STATUS);

  // Clock source selection and synchroniser choice
  always_comb begin
    instr_tick = (instr_q == `INSTR_DIV_LAST);
    instr_d = instr_q + 2'h1;
    case (ctrl_q.clock_select)
      CLK_INSTR: begin
        src_tick = instr_tick;
        is_async = 1'b0;
      end
      CLK_SYSTEM: begin
        src_tick = 1'b1;
        is_async = 1'b0;
      end
      CLK_EXT_PIN: begin
        src_tick = ext_rise & fall_seen_q;
        is_async = 1'b1;
      end
      CLK_LFOSC: begin
        src_tick = lfo_rise;
        is_async = 1'b1;
      end
      default: begin
        src_tick = 1'b0;
        is_async = 1'b0;
      end
    endcase
    // A rising edge counts only after the pin was seen low
    fall_seen_d = fall_seen_q;
    if (!ctrl_q.counter_on || wr_ctrl) begin
      fall_seen_d = 1'b0;
    end else if (!ext_level) begin
      fall_seen_d = 1'b1;
    end
    // Prescaler pulse carried as a toggle into the resynchroniser
    ptog_d = ptog_q ^ presc_pulse;
    if (is_async && !ctrl_q.sync_bypass) begin
      final_tick = ps_rise | ps_fall;
    end else begin
      final_tick = presc_pulse;
    end
  end

  // Clock path registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      instr_q <= `INSTR_DIV_RESET;
      fall_seen_q <= 1'b0;
      ptog_q <= 1'b0;
    end else begin
      instr_q <= instr_d;
      fall_seen_q <= fall_seen_d;
      ptog_q <= ptog_d;
    end
  end

  // Gate source, polarity, toggle and single-pulse stages
  always_comb begin
    case (gcfg_q.gate_source_select)
      GSRC_PIN: gsrc = gpin_level;
      GSRC_TIMER0: gsrc = TIMER0_OVERFLOW;
      GSRC_COMP: gsrc = COMPARATOR_SYNC_OUTPUT;
      default: gsrc = 1'b0;
    endcase
    gpol = gcfg_q.gate_polarity ? gsrc : ~gsrc;
    gpol_d = gpol;
    gpol_rise = gpol & ~gpol_q;
    // Toggle flop cleared when disabled or counter off
    toggle_d = toggle_q;
    if (!gcfg_q.gate_toggle_mode || !ctrl_q.counter_on) begin
      toggle_d = 1'b0;
    end else if (gpol_rise) begin
      toggle_d = ~toggle_q;
    end
    gmid = gcfg_q.gate_toggle_mode ? toggle_q : gpol;
    gmid_d = gmid;
    gmid_rise = gmid & ~gmid_q;
    gmid_fall = ~gmid & gmid_q;
    // Acquisition sequence; a software write clearing the arm bit overrides hardware
    pst_d = pst_q;
    case (pst_q)
      PULSE_IDLE: pst_d = PULSE_IDLE;
      PULSE_ARMED: begin
        if (gmid_rise) begin
          pst_d = PULSE_OPEN;
        end
      end
      PULSE_OPEN: begin
        if (gmid_fall) begin
          pst_d = PULSE_IDLE;
        end
      end
      default: pst_d = PULSE_IDLE;
    endcase
    if (wr_gate) begin
      if (!REG_WDATA[`GATE_ARM_BIT]) begin
        pst_d = PULSE_IDLE;
      end else if (pst_q == PULSE_IDLE) begin
        pst_d = PULSE_ARMED;
      end
    end
    // Final gate level shown to software and to the counter
    if (gcfg_q.gate_single_pulse_mode) begin
      glevel_d = (pst_q == PULSE_OPEN) && gmid;
    end else begin
      glevel_d = gmid;
    end
  end

  // Gate path registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      gpol_q <= 1'b0;
      toggle_q <= 1'b0;
      gmid_q <= 1'b0;
      pst_q <= PULSE_IDLE;
      glevel_q <= 1'b0;
    end else begin
      gpol_q <= gpol_d;
      toggle_q <= toggle_d;
      gmid_q <= gmid_d;
      pst_q <= pst_d;
      glevel_q <= glevel_d;
    end
  end

  // Counter, flags and register port
  always_comb begin
    // Count only while on, and gated only when the gate is enabled
    cnt_en = ctrl_q.counter_on && final_tick &&
             (!gcfg_q.gate_enable || glevel_q);
    count_d = count_q;
    if (cnt_en) begin
      count_d = count_q + 16'h0001;
    end
    // Software byte writes take priority over an increment
    if (wr_lo) begin
      count_d[7:0] = REG_WDATA;
    end
    if (wr_hi) begin
      count_d[15:8] = REG_WDATA;
    end
    // Flags: hardware set wins over a write-one clear
    ovf_d = ovf_q;
    if (wr_stat && REG_WDATA[`STAT_OVF_BIT]) begin
      ovf_d = 1'b0;
    end
    if (cnt_en && (count_q == `COUNT_MAX)) begin
      ovf_d = 1'b1;
    end
    gev_d = gev_q;
    if (wr_stat && REG_WDATA[`STAT_GATE_BIT]) begin
      gev_d = 1'b0;
    end
    if (glevel_q && !glevel_d) begin
      gev_d = 1'b1;
    end
    // Configuration writes, unimplemented bits kept zero
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = ctrl_t'(REG_WDATA & `CONTROL_WMASK);
    end
    gcfg_d = gcfg_q;
    if (wr_gate) begin
      gcfg_d = gcfg_t'(REG_WDATA & `GATE_WMASK);
    end
    // Read data for the cycle after the strobe
    rdata_d = `READ_ZERO;
    if (REG_RD) begin
      case (REG_ADDR)
        `ADDR_CONTROL: rdata_d = ctrl_q & `CONTROL_WMASK;
        `ADDR_GATE: begin
          rdata_d = gcfg_q;
          rdata_d[`GATE_ARM_BIT] = (pst_q != PULSE_IDLE);
          rdata_d[`GATE_LEVEL_BIT] = glevel_q;
        end
        `ADDR_COUNT_LO: rdata_d = count_q[7:0];
        `ADDR_COUNT_HI: rdata_d = count_q[15:8];
        `ADDR_STATUS: begin
          rdata_d[`STAT_OVF_BIT] = ovf_q;
          rdata_d[`STAT_GATE_BIT] = gev_q;
        end
        default: rdata_d = `READ_ZERO;
      endcase
    end
  end

  // Register file; power-on reset clears every writable bit
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= ctrl_t'(`CONTROL_RESET);
      gcfg_q <= gcfg_t'(`GATE_RESET);
      count_q <= `COUNT_RESET;
      ovf_q <= 1'b0;
      gev_q <= 1'b0;
      rdata_q <= `READ_ZERO;
    end else begin
      ctrl_q <= ctrl_d;
      gcfg_q <= gcfg_d;
      count_q <= count_d;
      ovf_q <= ovf_d;
      gev_q <= gev_d;
      rdata_q <= rdata_d;
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA = rdata_q;
  assign OVERFLOW_FLAG = ovf_q;
  assign GATE_EVENT_FLAG = gev_q;
  assign GATE_LEVEL = glevel_q;

endmodule

/* File: rtl/sync_edge.sv */
// Two-flop synchroniser with rise and fall detection.
module sync_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1_q, s1_d; // First stage, read only by second stage
  logic s2_q, s2_d; // Second stage, safe level
  logic s3_q, s3_d; // Delayed copy for edge detection

  // Next values of the shift chain
  always_comb begin
    s1_d = din;
    s2_d = s1_q;
    s3_d = s2_q;
  end

  // Chain registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // Outputs look only at the later stages
  assign level = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

endmodule

/* File: rtl/tick_prescaler.sv */
// Prescaler that passes one of every 1, 2, 4 or 8 ticks.
`include "timer_cfg.svh"
module tick_prescaler (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick,
  input wire logic [1:0] sel,
  output logic pulse
);

  logic [2:0] cnt_q, cnt_d; // Tick counter
  logic [2:0] mask; // Terminal count for the chosen ratio

  // Ratio decode and counter next value
  always_comb begin
    case (sel)
      2'b00: mask = `PRESC_MASK_1;
      2'b01: mask = `PRESC_MASK_2;
      2'b10: mask = `PRESC_MASK_4;
      default: mask = `PRESC_MASK_8;
    endcase
    pulse = tick & ((cnt_q & mask) == mask);
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = `PRESC_RESET;
    end else if (tick) begin
      cnt_d = cnt_q + 3'h1;
    end
  end

  // Counter register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= `PRESC_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

/* File: tb/gated_16bit_counter_timer_test.sv */
// Self-checking bench for the gated counter timer.
`include "timer_cfg.svh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  num_errors++; $display("Error %s exp %h got %h", n, e, a); end end
module gated_16bit_counter_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0, rst = 1'h1, wr_s = 1'h0, rd_s = 1'h0;
  logic run = 1'h0, man = 1'h1, gpin = 1'h0, t0 = 1'h0, cmp = 1'h0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic ovf, gev, glv, ext, osc;
  int num_errors = 0, num_checks = 0, cyc = 0;
  gated_counter_timer i_dut (.MCLK(mclk), .RST(rst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
    .EXT_CLOCK_PIN(ext), .LOW_FREQ_OSC(osc), .GATE_PIN(gpin),
    .TIMER0_OVERFLOW(t0), .COMPARATOR_SYNC_OUTPUT(cmp),
    .OVERFLOW_FLAG(ovf), .GATE_EVENT_FLAG(gev), .GATE_LEVEL(glv));
  timer_sources i_src (.clk(mclk), .run(run), .man(man), .ext_pin(ext),
    .osc(osc));
  always #25 mclk = ~mclk;
  // Bus cycles: one-cycle strobes launched just after a rising edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'h1;
    @(posedge mclk);
    wr_s <= 1'h0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'h1;
    @(posedge mclk);
    rd_s <= 1'h0;
    @(negedge mclk);
    d = rdata;
    @(posedge mclk);
  endtask
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK("register", e, d)
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Count advance over exactly 128 cycles after a control setting
  task automatic rate(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] x, y;
    wr(`ADDR_CONTROL, c);
    w(8);
    rd(`ADDR_COUNT_LO, x);
    w(125);
    rd(`ADDR_COUNT_LO, y);
    `CHK("rate", e, y - x)
  endtask
  // One gate pin pulse, then settle to mid-cycle for sampling
  task automatic pulse(input int n);
    @(posedge mclk);
    gpin <= 1'h1;
    w(n);
    gpin <= 1'h0;
    w(n);
    @(negedge mclk);
  endtask
  task automatic t_reset;
    logic [7:0] d;
    for (int a = 0; a < 6; a++) begin
      if (a != 1) rc(a[2:0], 8'h00);
    end
    rd(`ADDR_GATE, d);
    `CHK("gate reset", 8'h00, d & 8'hFB)
  endtask
  task automatic t_regs;
    wr(`ADDR_CONTROL, 8'hFF);
    rc(`ADDR_CONTROL, 8'hF5);
    wr(`ADDR_CONTROL, 8'h00);
    wr(`ADDR_COUNT_LO, 8'h34);
    wr(`ADDR_COUNT_HI, 8'h12);
    rc(`ADDR_COUNT_LO, 8'h34);
    rc(`ADDR_COUNT_HI, 8'h12);
    wr(3'h5, 8'hFF);
    rc(3'h5, 8'h00);
  endtask
  // Every prescale code on both internal clocks, then pin and oscillator
  task automatic t_rates;
    for (int p = 0; p < 4; p++) begin
      rate({2'h1, p[1:0], 4'h1}, 8'h80 >> p);
      rate({2'h0, p[1:0], 4'h1}, 8'h20 >> p);
    end
    run <= 1'h1;
    rate(8'h81, 8'h10);
    rate(8'h85, 8'h10);
    rate(8'hC1, 8'h08);
    rate(8'hC5, 8'h08);
    rate(8'h40, 8'h00);
    run <= 1'h0;
  endtask
  // Pin rises just as counting starts: only a rise after a fall may count
  task automatic t_fall;
    man <= 1'h0;
    wr(`ADDR_COUNT_LO, 8'h00);
    // Synced rise lands on the enabling edge, before any low is seen
    @(posedge mclk);
    man <= 1'h1;
    wr(`ADDR_CONTROL, 8'h85);
    w(10);
    man <= 1'h0;
    w(10);
    man <= 1'h1;
    w(10);
    rc(`ADDR_COUNT_LO, 8'h01);
    wr(`ADDR_CONTROL, 8'h00);
  endtask
  task automatic t_ovf;
    wr(`ADDR_COUNT_LO, 8'hFF);
    wr(`ADDR_COUNT_HI, 8'hFF);
    wr(`ADDR_STATUS, 8'h03);
    wr(`ADDR_CONTROL, 8'h41);
    wr(`ADDR_CONTROL, 8'h00);
    @(negedge mclk);
    `CHK("overflow", 1'h1, ovf)
    rc(`ADDR_COUNT_HI, 8'h00);
    wr(`ADDR_STATUS, 8'h01);
    @(negedge mclk);
    `CHK("overflow clear", 1'h0, ovf)
  endtask
  task automatic t_gate;
    wr(`ADDR_GATE, 8'hC0);
    rate(8'h41, 8'h00);
    gpin <= 1'h1;
    rate(8'h41, 8'h80);
    wr(`ADDR_GATE, 8'h80);
    rate(8'h41, 8'h00);
    gpin <= 1'h0;
    rate(8'h41, 8'h80);
    wr(`ADDR_GATE, 8'h40);
    rate(8'h41, 8'h80);
    wr(`ADDR_STATUS, 8'h02);
    // Each source alone high, then each alone low; reserved stays low
    for (int s = 0; s < 8; s++) begin
      @(posedge mclk);
      gpin <= (s[1:0] == 2'h0) ^ s[2];
      t0 <= (s[1:0] == 2'h1) ^ s[2];
      cmp <= (s[1:0] == 2'h2) ^ s[2];
      wr(`ADDR_GATE, {6'h10, s[1:0]});
      w(6);
      @(negedge mclk);
      `CHK("gate level", s < 3, glv)
    end
    `CHK("gate event", 1'h1, gev)
  endtask
  task automatic t_toggle;
    @(posedge mclk);
    gpin <= 1'h0;
    wr(`ADDR_GATE, 8'h60);
    pulse(6);
    `CHK("toggle", 1'h1, glv)
    pulse(6);
    `CHK("toggle", 1'h0, glv)
    pulse(6);
    wr(`ADDR_GATE, 8'h40);
    // Gate level register needs one more edge after the write
    w(2);
    @(negedge mclk);
    `CHK("toggle off", 1'h0, glv)
  endtask
  task automatic t_single;
    logic [7:0] d, x, y;
    wr(`ADDR_CONTROL, 8'h41);
    wr(`ADDR_GATE, 8'hD8);
    rd(`ADDR_GATE, d);
    `CHK("armed", 1'h1, d[3])
    wr(`ADDR_STATUS, 8'h02);
    rd(`ADDR_COUNT_LO, x);
    pulse(10);
    rd(`ADDR_GATE, d);
    `CHK("done", 1'h0, d[3])
    `CHK("event", 1'h1, gev)
    rd(`ADDR_COUNT_LO, y);
    `CHK("window", 1'h1, y != x)
    pulse(10);
    rd(`ADDR_COUNT_LO, x);
    `CHK("blocked", y, x)
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard well above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    t_reset();
    t_regs();
    t_rates();
    t_fall();
    t_ovf();
    t_gate();
    t_toggle();
    t_single();
    wrap_up();
  end
endmodule

/* File: tb/timer_checker.sv */
// Port checker for the gated counter timer.
`include "timer_cfg.svh"
module timer_checker (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic OVERFLOW_FLAG,
  input wire logic GATE_EVENT_FLAG,
  input wire logic GATE_LEVEL
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  // Status clear strobes for each flag
  logic clr_ovf;
  logic clr_gev;
  assign clr_ovf = REG_WR && REG_ADDR == `ADDR_STATUS && REG_WDATA[0];
  assign clr_gev = REG_WR && REG_ADDR == `ADDR_STATUS && REG_WDATA[1];
  AST_RDATA_IDLE: assert property (
    !REG_RD |=> REG_RDATA == 8'h00) else $error("read data not idle");
  AST_CTRL_MASK: assert property (
    REG_WR && REG_ADDR == `ADDR_CONTROL ##1 !REG_WR
    ##1 REG_RD && REG_ADDR == `ADDR_CONTROL
    |=> REG_RDATA == ($past(REG_WDATA, 3) & 8'hF5))
    else $error("control readback");
  AST_STATUS_RB: assert property (
    REG_RD && REG_ADDR == `ADDR_STATUS |=> REG_RDATA ==
    {6'h00, $past(GATE_EVENT_FLAG), $past(OVERFLOW_FLAG)})
    else $error("status readback");
  AST_LEVEL_RB: assert property (
    REG_RD && REG_ADDR == `ADDR_GATE |=>
    REG_RDATA[`GATE_LEVEL_BIT] == $past(GATE_LEVEL))
    else $error("gate level readback");
  AST_OVF_STICKY: assert property (
    OVERFLOW_FLAG && !clr_ovf |=> OVERFLOW_FLAG)
    else $error("overflow flag lost");
  AST_GEV_STICKY: assert property (
    GATE_EVENT_FLAG && !clr_gev |=> GATE_EVENT_FLAG)
    else $error("gate event flag lost");
  AST_GEV_SET: assert property (
    $fell(GATE_LEVEL) |-> ##[0:2] GATE_EVENT_FLAG)
    else $error("gate event not set");
  AST_GEV_CAUSE: assert property (
    $rose(GATE_EVENT_FLAG) |-> !GATE_LEVEL)
    else $error("gate event without fall");
endmodule

bind gated_counter_timer timer_checker i_chk (.MCLK(MCLK), .RST(RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .OVERFLOW_FLAG(OVERFLOW_FLAG),
  .GATE_EVENT_FLAG(GATE_EVENT_FLAG), .GATE_LEVEL(GATE_LEVEL));

/* File: tb/timer_sources.sv */
// Far-side clock sources: external clock pin and slow oscillator.
module timer_sources (
  input wire logic clk,
  input wire logic run,
  input wire logic man,
  output logic ext_pin,
  output logic osc
);
  timeunit 1ns;
  timeprecision 1ns;
  // Free divider that paces both sources
  logic [3:0] cnt_q = 4'h0;
  always @(posedge clk) begin
    cnt_q <= cnt_q + 4'h1;
  end
  // Pin clock runs at one eighth of the system clock only while asked,
  // otherwise it rests at the level the bench requests
  assign ext_pin = run ? cnt_q[2] : man;
  // Slow oscillator runs free at one sixteenth
  assign osc = cnt_q[3];
endmodule
